// >>> core/ssmp_port.sv
// Synchronous serial port: APB registers, master clock, shift engines, receive FIFO
//
// Functional notes
// - Data line driver is off while receiving.
// - Reception starts when single or continuous receive enable is set.
// - Single receive: one character of clocks, then single enable self-clears.
// - Continuous receive: master clocks until software clears the enable or an overrun occurs.
// - Continuous enable cleared mid-character stops clock, drops partial character.
// - Both enables set: single clears after first character, continuous continues.
// - Data sampled on trailing clock edge into receive shift register.
// - Completed character enters two-entry FIFO; pending flag while unread data.
// - Receive data read returns low byte of oldest unread character.
// - Slave mode: clock line driver off, clock taken from outside.
// - Data changes on leading edge, one bit per clock cycle.
// - Third character with full FIFO sets overrun, FIFO kept intact.
// - While overrun, stored characters readable, no new characters accepted.
// - Overrun in single receive clears on receive data read.
// - Overrun in continuous receive clears on continuous or port enable clear.
// - Nine-bit receive shifts nine bits; ninth bit of oldest shown.
// - Master drives clock line with its driver enabled for send and receive.
// - Polarity set: idle high, data on falling edges; clear: opposite.
// - Written character waits until shifter finishes, then loads and shifts.
`timescale 1ns/1ps
`include "ssmp_consts.svh"

module ssmp_port
   import ssmp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`SSMP_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic clock_line_in,
   output ssmp_pin_drive_type clock_line_drive,
   input wire logic data_line_in,
   output ssmp_pin_drive_type data_line_drive
);

   function automatic logic addr_mapped(input logic [`SSMP_ADDR_W-1:0] a);
      case (a)
         `SSMP_OFS_TX_STATUS, `SSMP_OFS_RX_STATUS, `SSMP_OFS_BAUD_CTRL, `SSMP_OFS_BAUD_LOW,
         `SSMP_OFS_BAUD_HIGH, `SSMP_OFS_TX_DATA, `SSMP_OFS_RX_DATA, `SSMP_OFS_FLAGS: addr_mapped = 1'b1;
         default: addr_mapped = 1'b0;
      endcase
   endfunction : addr_mapped

   logic [7:0] transmit_status_control;
   logic [7:0] receive_status_control;
   logic [7:0] baud_control;
   logic [7:0] baud_divisor_low_byte;
   logic [7:0] baud_divisor_high_byte;
   logic overrun_error_flag;
   logic overrun_from_single;
   ssmp_char_type fifo_mem [2];
   logic fifo_rd_ptr;
   logic fifo_wr_ptr;
   logic [1:0] fifo_count;
   ssmp_char_type transmit_data;
   logic tx_hold_full;
   logic [8:0] transmit_shift_register;
   logic [3:0] tx_bits_left;
   logic tx_busy;
   logic [8:0] receive_shift_register;
   logic [3:0] rx_bit_index;
   logic [15:0] half_count;
   logic clk_active;
   logic data_out;
   logic clk_sync1, clk_sync2, clk_prev;
   logic data_sync1, data_sync2;

   // APB: one access cycle, read data captured during setup
   logic setup_phase, wr_access, rd_access;
   assign setup_phase = psel && !penable;
   assign wr_access = psel && penable && pwrite;
   assign rd_access = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_mapped(paddr);

   logic port_enable, single_receive_enable, continuous_receive_enable, clock_source_master;
   logic transmit_enable, clock_idle_polarity, receive_nine_bit_option, transmit_nine_bit_option;
   assign port_enable = receive_status_control[`SSMP_RX_PORT_ENABLE];
   assign single_receive_enable = receive_status_control[`SSMP_RX_SINGLE];
   assign continuous_receive_enable = receive_status_control[`SSMP_RX_CONT];
   assign receive_nine_bit_option = receive_status_control[`SSMP_RX_NINE];
   assign clock_source_master = transmit_status_control[`SSMP_TX_MASTER];
   assign transmit_enable = transmit_status_control[`SSMP_TX_ENABLE];
   assign transmit_nine_bit_option = transmit_status_control[`SSMP_TX_NINE];
   assign clock_idle_polarity = baud_control[`SSMP_BAUD_POLARITY];

   logic rx_mode, tx_mode, receive_pending_flag, transmit_buffer_empty_flag;
   assign rx_mode = port_enable && (single_receive_enable || continuous_receive_enable);
   assign tx_mode = port_enable && transmit_enable && !rx_mode;
   assign receive_pending_flag = fifo_count != `SSMP_FIFO_EMPTY;
   assign transmit_buffer_empty_flag = !tx_hold_full;

   logic rx_pop;
   assign rx_pop = rd_access && paddr == `SSMP_OFS_RX_DATA && receive_pending_flag;

   logic wr_tx_status, wr_rx_status, wr_tx_data;
   assign wr_tx_status = wr_access && paddr == `SSMP_OFS_TX_STATUS;
   assign wr_rx_status = wr_access && paddr == `SSMP_OFS_RX_STATUS;
   assign wr_tx_data = wr_access && paddr == `SSMP_OFS_TX_DATA;

   // Two-flop synchronisers on both line inputs
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         clk_sync1 <= 1'b0;
         clk_sync2 <= 1'b0;
         clk_prev <= 1'b0;
         data_sync1 <= 1'b0;
         data_sync2 <= 1'b0;
      end else begin
         clk_sync1 <= clock_line_in;
         clk_sync2 <= clk_sync1;
         clk_prev <= clk_sync2;
         data_sync1 <= data_line_in;
         data_sync2 <= data_sync1;
      end
   end

   // Master bit clock: one half period is divisor+1 system clocks
   logic [15:0] divisor;
   logic master_run, half_tick, lead_ev, trail_ev, slave_lead, slave_trail;
   assign divisor = baud_control[`SSMP_BAUD_WIDE] ? {baud_divisor_high_byte, baud_divisor_low_byte}
                                                 : {8'h00, baud_divisor_low_byte};
   assign master_run = port_enable && clock_source_master &&
                       ((tx_mode && tx_busy) || (rx_mode && !overrun_error_flag));
   assign half_tick = master_run && half_count == divisor;
   // Leading edge is the idle-to-active change; polarity only flips the pin level
   assign slave_lead = (clk_sync2 ^ clock_idle_polarity) && !(clk_prev ^ clock_idle_polarity);
   assign slave_trail = !(clk_sync2 ^ clock_idle_polarity) && (clk_prev ^ clock_idle_polarity);
   assign lead_ev = clock_source_master ? (half_tick && !clk_active) : (port_enable && slave_lead);
   assign trail_ev = clock_source_master ? (half_tick && clk_active) : (port_enable && slave_trail);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         half_count <= 16'h0000;
         clk_active <= 1'b0;
      end else if (!master_run) begin
         half_count <= 16'h0000;
         clk_active <= 1'b0;
      end else if (half_tick) begin
         half_count <= 16'h0000;
         clk_active <= !clk_active;
      end else begin
         half_count <= half_count + 16'h0001;
      end
   end

   // Pin drivers; output enable is low while driving
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         clock_line_drive <= '{out: 1'b0, oe_n: 1'b1};
         data_line_drive <= '{out: 1'b0, oe_n: 1'b1};
      end else begin
         clock_line_drive.out <= clk_active ^ clock_idle_polarity;
         clock_line_drive.oe_n <= !(port_enable && clock_source_master && (transmit_enable || rx_mode));
         data_line_drive.out <= data_out;
         data_line_drive.oe_n <= !tx_mode;
      end
   end

   // Transmit holding register and shifter
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         transmit_data <= '0;
         tx_hold_full <= 1'b0;
         transmit_shift_register <= 9'h000;
         tx_bits_left <= 4'h0;
         tx_busy <= 1'b0;
         data_out <= 1'b0;
      end else if (!port_enable) begin
         tx_hold_full <= 1'b0;
         tx_busy <= 1'b0;
         tx_bits_left <= 4'h0;
      end else begin
         if (wr_tx_data) begin
            transmit_data <= '{ninth: transmit_status_control[`SSMP_TX_NINTH_VALUE], low: pwdata[7:0]};
            tx_hold_full <= 1'b1;
         end else if (tx_hold_full && !tx_busy && tx_mode) begin
            tx_hold_full <= 1'b0;
         end
         if (!tx_busy) begin
            if (tx_hold_full && tx_mode) begin
               transmit_shift_register <= {transmit_data.ninth, transmit_data.low};
               tx_bits_left <= transmit_nine_bit_option ? `SSMP_BITS_WIDE : `SSMP_BITS_NARROW;
               tx_busy <= 1'b1;
            end
         end else if (tx_mode && lead_ev) begin
            data_out <= transmit_shift_register[0];
            transmit_shift_register <= {1'b0, transmit_shift_register[8:1]};
         end else if (tx_mode && trail_ev) begin
            tx_bits_left <= tx_bits_left - 4'h1;
            if (tx_bits_left == 4'h1) begin
               tx_busy <= 1'b0;
            end
         end
      end
   end

   // Receive shifter
   logic [3:0] rx_bits;
   logic rx_sample, rx_done, rx_push;
   ssmp_char_type rx_char;
   assign rx_bits = receive_nine_bit_option ? `SSMP_BITS_WIDE : `SSMP_BITS_NARROW;
   assign rx_sample = rx_mode && trail_ev && !overrun_error_flag;
   assign rx_done = rx_sample && rx_bit_index == rx_bits - 4'h1;
   assign rx_push = rx_done && fifo_count != `SSMP_FIFO_FULL;
   always_comb begin
      rx_char = receive_shift_register;
      rx_char[rx_bit_index] = data_sync2;
      if (!receive_nine_bit_option) begin
         rx_char.ninth = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         receive_shift_register <= 9'h000;
         rx_bit_index <= 4'h0;
      end else if (!rx_mode) begin
         receive_shift_register <= 9'h000;
         rx_bit_index <= 4'h0;
      end else if (rx_done) begin
         receive_shift_register <= 9'h000;
         rx_bit_index <= 4'h0;
      end else if (rx_sample) begin
         receive_shift_register[rx_bit_index] <= data_sync2;
         rx_bit_index <= rx_bit_index + 4'h1;
      end
   end

   // Two-entry receive FIFO; array declared with the other state, head also read through fifo_head
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         fifo_mem[0] <= '0;
         fifo_mem[1] <= '0;
         fifo_rd_ptr <= 1'b0;
         fifo_wr_ptr <= 1'b0;
         fifo_count <= `SSMP_FIFO_EMPTY;
      end else if (!port_enable) begin
         fifo_rd_ptr <= 1'b0;
         fifo_wr_ptr <= 1'b0;
         fifo_count <= `SSMP_FIFO_EMPTY;
      end else begin
         if (rx_push) begin
            fifo_mem[fifo_wr_ptr] <= rx_char;
            fifo_wr_ptr <= !fifo_wr_ptr;
         end
         if (rx_pop) begin
            fifo_rd_ptr <= !fifo_rd_ptr;
         end
         fifo_count <= fifo_count + {1'b0, rx_push} - {1'b0, rx_pop};
      end
   end

   // Overrun flag: the setting event wins over any clear in the same cycle
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         overrun_error_flag <= 1'b0;
         overrun_from_single <= 1'b0;
      end else if (rx_done && fifo_count == `SSMP_FIFO_FULL) begin
         overrun_error_flag <= 1'b1;
         overrun_from_single <= single_receive_enable && !continuous_receive_enable;
      end else if (!port_enable) begin
         overrun_error_flag <= 1'b0;
      end else if (overrun_from_single && rx_pop) begin
         overrun_error_flag <= 1'b0;
      end else if (!overrun_from_single && !continuous_receive_enable) begin
         overrun_error_flag <= 1'b0;
      end
   end

   // Control registers; hardware clears single receive after each finished character
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         receive_status_control <= `SSMP_RESET_BYTE;
      end else if (wr_rx_status) begin
         receive_status_control <= pwdata[7:0];
      end else if (rx_done) begin
         receive_status_control[`SSMP_RX_SINGLE] <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         transmit_status_control <= `SSMP_RESET_BYTE;
         baud_control <= `SSMP_RESET_BYTE;
         baud_divisor_low_byte <= `SSMP_RESET_BYTE;
         baud_divisor_high_byte <= `SSMP_RESET_BYTE;
      end else if (wr_access) begin
         if (wr_tx_status) transmit_status_control <= pwdata[7:0];
         if (paddr == `SSMP_OFS_BAUD_CTRL) baud_control <= pwdata[7:0];
         if (paddr == `SSMP_OFS_BAUD_LOW) baud_divisor_low_byte <= pwdata[7:0];
         if (paddr == `SSMP_OFS_BAUD_HIGH) baud_divisor_high_byte <= pwdata[7:0];
      end
   end

   // Read data is registered in the setup cycle and held through the access
   ssmp_char_type fifo_head;
   logic [7:0] tx_status_view, rx_status_view;
   assign fifo_head = fifo_mem[fifo_rd_ptr];
   always_comb begin
      tx_status_view = transmit_status_control;
      tx_status_view[`SSMP_TX_SHIFT_EMPTY] = !tx_busy;
      rx_status_view = receive_status_control;
      rx_status_view[`SSMP_RX_OVERRUN] = overrun_error_flag;
      rx_status_view[`SSMP_RX_NINTH_VALUE] = fifo_head.ninth;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= 32'h00000000;
      end else if (setup_phase && !pwrite) begin
         case (paddr)
            `SSMP_OFS_TX_STATUS: prdata <= {24'h000000, tx_status_view};
            `SSMP_OFS_RX_STATUS: prdata <= {24'h000000, rx_status_view};
            `SSMP_OFS_BAUD_CTRL: prdata <= {24'h000000, baud_control};
            `SSMP_OFS_BAUD_LOW: prdata <= {24'h000000, baud_divisor_low_byte};
            `SSMP_OFS_BAUD_HIGH: prdata <= {24'h000000, baud_divisor_high_byte};
            `SSMP_OFS_TX_DATA: prdata <= {24'h000000, transmit_data.low};
            `SSMP_OFS_RX_DATA: prdata <= {24'h000000, fifo_head.low};
            `SSMP_OFS_FLAGS: prdata <= {30'h0, receive_pending_flag, transmit_buffer_empty_flag};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   AST_RX_DRIVER_OFF: assert property (rx_mode |=> data_line_drive.oe_n)
      else $error("data line driven during receive");
   AST_SLAVE_CLOCK_OFF: assert property (!clock_source_master |=> clock_line_drive.oe_n)
      else $error("clock line driven in slave mode");
   AST_MASTER_CLOCK_ON: assert property (port_enable && clock_source_master && rx_mode |=> !clock_line_drive.oe_n)
      else $error("master clock driver not enabled");
   AST_IDLE_LEVEL: assert property (!master_run ##1 !master_run |=> clock_line_drive.out == $past(clock_idle_polarity))
      else $error("clock idle level wrong");
   AST_SINGLE_SELF_CLEAR: assert property (rx_done && !wr_rx_status |=> !single_receive_enable)
      else $error("single receive did not clear");
   AST_CONT_STOP: assert property ($fell(continuous_receive_enable) && !single_receive_enable |=> !clk_active && rx_bit_index == 4'h0)
      else $error("clock not stopped on continuous clear");
   AST_OVERRUN_SET: assert property (rx_done && fifo_count == `SSMP_FIFO_FULL |=> overrun_error_flag && fifo_count == `SSMP_FIFO_FULL)
      else $error("overrun not flagged or FIFO changed");
   AST_OVERRUN_BLOCK: assert property (overrun_error_flag |=> fifo_count <= $past(fifo_count) && rx_bit_index == 4'h0)
      else $error("character accepted during overrun");
   AST_OVERRUN_READ_CLEAR: assert property (overrun_error_flag && overrun_from_single && rx_pop && port_enable |=> !overrun_error_flag)
      else $error("overrun not cleared by read");
   AST_PENDING_TRACKS: assert property (rx_push && !rx_pop |=> receive_pending_flag)
      else $error("pending flag missing after push");
   AST_TX_HANDOFF: assert property (!tx_busy && tx_hold_full && tx_mode && !wr_tx_data |=> tx_busy && transmit_buffer_empty_flag)
      else $error("holding register not handed off");

   COV_TX_DONE: cover property (tx_busy && tx_mode ##1 !tx_busy);
   COV_RX_CHAR: cover property (rx_push);
   COV_OVERRUN: cover property (rx_done && fifo_count == `SSMP_FIFO_FULL);
   COV_BOTH_ENABLES: cover property (rx_done && single_receive_enable && continuous_receive_enable);

endmodule : ssmp_port

// >>> common/ssmp_consts.svh
// Register map, field positions and reset values of the synchronous serial port
`ifndef SSMP_CONSTS_SVH
`define SSMP_CONSTS_SVH

`define SSMP_ADDR_W 8
`define SSMP_OFS_TX_STATUS 8'h00
`define SSMP_OFS_RX_STATUS 8'h04
`define SSMP_OFS_BAUD_CTRL 8'h08
`define SSMP_OFS_BAUD_LOW 8'h0C
`define SSMP_OFS_BAUD_HIGH 8'h10
`define SSMP_OFS_TX_DATA 8'h14
`define SSMP_OFS_RX_DATA 8'h18
`define SSMP_OFS_FLAGS 8'h1C

// Transmit status/control bits
`define SSMP_TX_MASTER 7
`define SSMP_TX_NINE 6
`define SSMP_TX_ENABLE 5
`define SSMP_TX_SYNC 4
`define SSMP_TX_HIGH_SPEED 2
`define SSMP_TX_SHIFT_EMPTY 1
`define SSMP_TX_NINTH_VALUE 0
// Receive status/control bits
`define SSMP_RX_PORT_ENABLE 7
`define SSMP_RX_NINE 6
`define SSMP_RX_SINGLE 5
`define SSMP_RX_CONT 4
`define SSMP_RX_OVERRUN 1
`define SSMP_RX_NINTH_VALUE 0
// Baud control bits
`define SSMP_BAUD_POLARITY 4
`define SSMP_BAUD_WIDE 3
// Flag register bits
`define SSMP_FLAG_RX_PENDING 1
`define SSMP_FLAG_TX_EMPTY 0

`define SSMP_RESET_BYTE 8'h00
`define SSMP_BITS_NARROW 4'h8
`define SSMP_BITS_WIDE 4'h9
`define SSMP_FIFO_FULL 2'h2
`define SSMP_FIFO_EMPTY 2'h0

`endif

// >>> common/ssmp_pkg.sv
// Types shared by the synchronous serial port
package ssmp_pkg;
   typedef struct packed {
      logic out;
      logic oe_n;
   } ssmp_pin_drive_type;

   typedef struct packed {
      logic ninth;
      logic [7:0] low;
   } ssmp_char_type;
endpackage : ssmp_pkg

// >>> tb/ssmp_link_partner.sv
// Far-side serial device: answers the port's clock, or makes the clock itself
`timescale 1ns/1ps
module ssmp_link_partner (
   input wire logic ref_clk,
   input wire logic pol,
   input wire logic ck,
   input wire logic dt,
   output logic p_ck,
   output logic p_ck_oe,
   output logic p_d,
   output logic p_d_oe
);
   logic send_en = 1'b0;
   logic [8:0] send_word = 9'h000;
   logic [15:0] got = 16'h0000;
   int nbits = 8;
   int idx = 0;
   int got_cnt = 0;
   int lead_cnt = 0;
   initial begin
      p_ck = 1'b0;
      p_ck_oe = 1'b0;
      p_d = 1'b0;
   end
   // Released data line is left to the bench, which scrambles it
   always @(posedge ref_clk) begin
      p_d_oe <= send_en;
   end
   // Shift logic follows the line itself; a ref_clk hop here would eat the master's sampling margin
   always @(ck) begin
      if (ck === ~pol) begin
         lead_cnt <= lead_cnt + 1;
         p_d <= send_word[idx];
         idx <= (idx == nbits - 1) ? 0 : idx + 1;
      end else if (ck === pol && got_cnt < 16) begin
         got[got_cnt] <= dt;
         got_cnt <= got_cnt + 1;
      end
   end
   task clear();
      idx = 0;
      got_cnt = 0;
      lead_cnt = 0;
      got = 16'h0000;
   endtask : clear
   // Clock stands at its idle level outside the frame
   task run_clk(input int n);
      p_ck = pol;
      p_ck_oe = 1'b1;
      #7;
      repeat (n) begin
         #80 p_ck = ~p_ck;
         #80 p_ck = ~p_ck;
      end
   endtask : run_clk
endmodule : ssmp_link_partner

// >>> tb/tb.sv
// Self-checking bench for the synchronous serial port
`timescale 1ns/1ps
`include "ssmp_consts.svh"
module tb;
   import ssmp_pkg::*;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, err, pol = 1'b0, junk = 1'b0, ck_w, dt_w, p_ck, p_ck_oe, p_d, p_d_oe;
   logic [8:0] w;
   logic [7:0] b;
   ssmp_pin_drive_type clock_line_drive, data_line_drive;
   int bad_count = 0;
   int check_count = 0;
   int k, i, n;
   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk) junk <= ~junk;
   assign ck_w = !clock_line_drive.oe_n ? clock_line_drive.out : (p_ck_oe ? p_ck : pol);
   assign dt_w = !data_line_drive.oe_n ? data_line_drive.out : (p_d_oe ? p_d : junk);
   ssmp_port u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .clock_line_in(ck_w),
      .clock_line_drive(clock_line_drive), .data_line_in(dt_w), .data_line_drive(data_line_drive));
   ssmp_link_partner u_partner (.ref_clk(ref_clk), .pol(pol), .ck(ck_w), .dt(dt_w), .p_ck(p_ck),
      .p_ck_oe(p_ck_oe), .p_d(p_d), .p_d_oe(p_d_oe));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Bounded poll so a stuck flag ends in a mismatch, not a hang
   task poll(input logic [7:0] a, input int bn, input logic v);
      apb(1'b0, a, 8'h00);
      for (i = 0; i < 300 && r[bn] !== v; i++) begin
         apb(1'b0, a, 8'h00);
      end
      chk(r[bn], v);
   endtask : poll
   task wait_bits(input int nb);
      for (i = 0; i < 3000 && u_partner.got_cnt != nb; i++) begin
         @(posedge ref_clk);
      end
   endtask : wait_bits
   task end_of_test();
      $display("checks=%0d bad=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #1000000;
      bad_count++;
      end_of_test();
   end
   initial begin
      void'($urandom(32'h30b1dff7));
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
      apb(1'b1, `SSMP_OFS_BAUD_LOW, 8'h03);
      apb(1'b1, `SSMP_OFS_TX_STATUS, 8'hB0);
      apb(1'b1, `SSMP_OFS_RX_STATUS, 8'h80);
      apb(1'b1, 8'h40, 8'hFF);
      chk(err, 1'b1);
      apb(1'b0, 8'h40, 8'h00);
      chk(r, 32'h0);
      for (k = 0; k < 2; k++) begin
         pol <= k[0];
         apb(1'b1, `SSMP_OFS_BAUD_CTRL, {3'h0, k[0], 4'h0});
         // New idle level reaches the pin a cycle later; it must not count as a bit
         repeat (2) @(posedge ref_clk);
         u_partner.clear();
         w = 9'($urandom);
         b = 8'($urandom);
         apb(1'b1, `SSMP_OFS_TX_DATA, w[7:0]);
         apb(1'b0, `SSMP_OFS_FLAGS, 8'h00);
         chk(r[0], 1'b1);
         apb(1'b1, `SSMP_OFS_TX_DATA, b);
         apb(1'b0, `SSMP_OFS_FLAGS, 8'h00);
         chk(r[0], 1'b0);
         chk(clock_line_drive.oe_n, 1'b0);
         wait_bits(16);
         chk(u_partner.got, {b, w[7:0]});
         chk(clock_line_drive.out, k[0]);
      end
      apb(1'b1, `SSMP_OFS_TX_STATUS, 8'hF1);
      u_partner.clear();
      apb(1'b1, `SSMP_OFS_TX_DATA, w[7:0]);
      wait_bits(9);
      chk(u_partner.got, {7'h0, 1'b1, w[7:0]});
      pol <= 1'b0;
      apb(1'b1, `SSMP_OFS_BAUD_CTRL, 8'h00);
      apb(1'b1, `SSMP_OFS_TX_STATUS, 8'hB0);
      u_partner.clear();
      u_partner.send_word = 9'($urandom);
      u_partner.nbits = 8;
      u_partner.send_en = 1'b1;
      for (k = 0; k < 3; k++) begin
         apb(1'b1, `SSMP_OFS_RX_STATUS, 8'hA0);
         poll(`SSMP_OFS_RX_STATUS, 5, 1'b0);
      end
      chk(u_partner.lead_cnt, 24);
      chk(r[1], 1'b1);
      apb(1'b0, `SSMP_OFS_RX_DATA, 8'h00);
      chk(r, {24'h0, u_partner.send_word[7:0]});
      apb(1'b0, `SSMP_OFS_RX_STATUS, 8'h00);
      chk(r[1], 1'b0);
      apb(1'b0, `SSMP_OFS_FLAGS, 8'h00);
      chk(r[1], 1'b1);
      apb(1'b0, `SSMP_OFS_RX_DATA, 8'h00);
      chk(r, {24'h0, u_partner.send_word[7:0]});
      apb(1'b0, `SSMP_OFS_FLAGS, 8'h00);
      chk(r[1], 1'b0);
      u_partner.clear();
      u_partner.send_word = 9'($urandom);
      u_partner.nbits = 9;
      apb(1'b1, `SSMP_OFS_RX_STATUS, 8'hF0);
      poll(`SSMP_OFS_RX_STATUS, 1, 1'b1);
      chk(data_line_drive.oe_n, 1'b1);
      chk(r[5], 1'b0);
      apb(1'b1, `SSMP_OFS_RX_STATUS, 8'hC0);
      for (k = 0; k < 2; k++) begin
         apb(1'b0, `SSMP_OFS_RX_STATUS, 8'h00);
         chk(r[1:0], {1'b0, u_partner.send_word[8]});
         apb(1'b0, `SSMP_OFS_RX_DATA, 8'h00);
         chk(r, {24'h0, u_partner.send_word[7:0]});
      end
      u_partner.clear();
      apb(1'b1, `SSMP_OFS_RX_STATUS, 8'hD0);
      for (i = 0; i < 500 && u_partner.lead_cnt < 4; i++) begin
         @(posedge ref_clk);
      end
      apb(1'b1, `SSMP_OFS_RX_STATUS, 8'hC0);
      repeat (4) @(posedge ref_clk);
      n = u_partner.lead_cnt;
      repeat (40) @(posedge ref_clk);
      chk(u_partner.lead_cnt, n);
      apb(1'b0, `SSMP_OFS_FLAGS, 8'h00);
      chk(r[1], 1'b0);
      apb(1'b1, `SSMP_OFS_TX_STATUS, 8'h30);
      apb(1'b1, `SSMP_OFS_RX_STATUS, 8'h90);
      u_partner.clear();
      u_partner.send_word = 9'($urandom);
      u_partner.nbits = 8;
      chk(clock_line_drive.oe_n, 1'b1);
      u_partner.run_clk(8);
      poll(`SSMP_OFS_FLAGS, 1, 1'b1);
      apb(1'b0, `SSMP_OFS_RX_DATA, 8'h00);
      chk(r, {24'h0, u_partner.send_word[7:0]});
      u_partner.send_en = 1'b0;
      end_of_test();
   end
endmodule : tb
